// ---- src/sbcr_params.svh ----
// constants for the stepper bridge current regulator
`ifndef SBCR_PARAMS_SVH
`define SBCR_PARAMS_SVH
`define SBCR_CLK_MHZ        40
`define SBCR_TOFF_FIXED_US  30
`define SBCR_TBLANK_US      1
`define SBCR_TOFF_FIXED_CYC (`SBCR_TOFF_FIXED_US * `SBCR_CLK_MHZ)
`define SBCR_TBLANK_CYC     (`SBCR_TBLANK_US * `SBCR_CLK_MHZ)
`define SBCR_OFF_TIME_SET_PIN_DIV       825
`define SBCR_FAST_NUM       5
`define SBCR_FAST_SHIFT     4
`define SBCR_REG_CTRL       5'h00
`define SBCR_REG_OFFT       5'h04
`define SBCR_REG_STATUS     5'h08
`define SBCR_REG_IRQ_STAT   5'h0c
`define SBCR_REG_IRQ_CLR    5'h10
`define SBCR_REG_IRQ_EN     5'h14
`define SBCR_CTRL_PH_A      0
`define SBCR_CTRL_LVL_A     1
`define SBCR_CTRL_PH_B      3
`define SBCR_CTRL_LVL_B     4
`define SBCR_CTRL_W         6
`define SBCR_CTRL_RST       6'h09
`define SBCR_OFFT_RES_W     20
`define SBCR_OFFT_MODE      20
`define SBCR_OFFT_RST       21'h000000
`define SBCR_IRQ_W          6
`define SBCR_LVL_OFF        2'h3
`define SBCR_GATE_FWD       4'h9
`define SBCR_GATE_REV       4'h6
`define SBCR_GATE_SLOW      4'h5
`endif

// ---- src/sbcr_pkg.sv ----
// types shared by the stepper bridge current regulator
package sbcr_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_FAST, ST_SLOW} sbcr_state_type;
	typedef struct packed {
		logic hs_a;
		logic ls_a;
		logic hs_b;
		logic ls_b;
	} sbcr_gate_type;
	typedef logic [16:0] sbcr_cnt_type;
endpackage

// ---- src/sbcr_top.sv ----
// dual full-bridge fixed off-time pwm current regulator with avalon slave
//
// Notes on behaviour
// - each bridge runs its own fixed off-time pwm loop
// - two level bits pick 100, 66 or 33 percent, or disable bridge
// - on-phase drives one diagonal high-side plus low-side pair
// - comparator trip ends on-phase, drops high side, starts off-time
// - fixed mode gives a 30 us off-time
// - resistor mode gives off-time of resistance over 825 microseconds
// - comparator ignored for 1 us after each regulator switching
// - trip right after blanking gives off-time then retry, repeating
// - short to ground latches bridge off until sleep released
// - gate regulator fault disables all switches
// - overtemperature or pump undervoltage disables, recovers when cleared
// - power-on reset disables switches and sets home step
// - sleep low disables switches, regulator and charge pump
// - fast decay first 31.25 percent of off-time, then slow
// - decay turns on recirculation switches actively
// - rectification stops when winding current nears zero
// - phase and level fields give full, half, quarter steps
`timescale 1ns/1ps
`include "sbcr_params.svh"
`default_nettype none
module sbcr_top
	import sbcr_pkg::*;
(
	// clock and reset
	input  wire logic                   clk_sys,
	input  wire logic                   resetn,
	// avalon-mm slave
	input  wire logic [4:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	output logic                        irq,
	// pins from the analog side
	input  wire logic                   sleep_n,
	input  wire logic                   bridge_a_sense_input,
	input  wire logic                   bridge_b_sense_input,
	input  wire logic [1:0]             zero_current,
	input  wire logic [1:0]             short_to_gnd,
	input  wire logic                   gate_regulator_fault,
	input  wire logic                   overtemp,
	input  wire logic                   charge_pump_reservoir_uv,
	// drives to the bridges
	output sbcr_gate_type [1:0]         bridge_gate,
	output logic [3:0]                  trip_level_sel,
	output logic                        charge_pump_en
);
	localparam int NSYNC = 10;
	logic [NSYNC-1:0]               sync1_q;
	logic [NSYNC-1:0]               sync2_q;
	logic                           sleep_s;
	logic                           sleep_prev_q;
	logic                           sleep_rise;
	logic [1:0]                     sense_s;
	logic [1:0]                     zero_s;
	logic [1:0]                     s2g_s;
	logic                           gate_regulator_output_s;
	logic                           ot_s;
	logic                           cpuv_s;
	logic                           shut;
	logic [`SBCR_CTRL_W-1:0]        ctrl_q;
	logic [`SBCR_OFFT_MODE:0]       offt_q;
	logic [`SBCR_IRQ_W-1:0]         irq_stat_q;
	logic [`SBCR_IRQ_W-1:0]         irq_en_q;
	logic [`SBCR_IRQ_W-1:0]         irq_ev;
	logic [`SBCR_IRQ_W-1:0]         irq_clr;
	logic [31:0]                    wmask;
	logic [31:0]                    rd_mux;
	logic                           wr_fire;
	logic [25:0]                    res_prod;
	logic [25:0]                    res_cyc;
	sbcr_cnt_type                   off_cyc;
	sbcr_cnt_type                   fast_cyc;
	sbcr_cnt_type                   slow_len;
	logic [1:0]                     phase;
	logic [1:0][1:0]                level;
	logic [1:0]                     run;
	logic [1:0]                     trip_ev;
	logic [1:0]                     s2g_q;
	sbcr_state_type [1:0]           state_q;
	sbcr_cnt_type [1:0]             tmr_q;
	logic [1:0][5:0]                blank_q;
	sbcr_gate_type [1:0]            gate_q;

	// pins are asynchronous to clk_sys
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {charge_pump_reservoir_uv, overtemp, gate_regulator_fault,
				short_to_gnd, zero_current, bridge_b_sense_input,
				bridge_a_sense_input, sleep_n};
			sync2_q <= sync1_q;
		end
	end
	assign sleep_s = sync2_q[0];
	assign sense_s = sync2_q[2:1];
	assign zero_s  = sync2_q[4:3];
	assign s2g_s   = sync2_q[6:5];
	assign gate_regulator_output_s  = sync2_q[7];
	assign ot_s    = sync2_q[8];
	assign cpuv_s  = sync2_q[9];
	assign shut    = gate_regulator_output_s | ot_s | cpuv_s;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sleep_prev_q <= 1'b0;
		end else begin
			sleep_prev_q <= sleep_s;
		end
	end
	assign sleep_rise = sleep_s & ~sleep_prev_q;
	// off-time length in cycles; divider is slow but only sees a register
	always_comb begin
		res_prod = 26'(offt_q[`SBCR_OFFT_RES_W-1:0]) * 26'(`SBCR_CLK_MHZ);
		res_cyc  = res_prod / 26'(`SBCR_OFF_TIME_SET_PIN_DIV);
		if (offt_q[`SBCR_OFFT_MODE]) begin
			off_cyc = sbcr_cnt_type'(res_cyc);
		end else begin
			off_cyc = sbcr_cnt_type'(`SBCR_TOFF_FIXED_CYC);
		end
		if (off_cyc == '0) begin
			off_cyc = sbcr_cnt_type'(1);
		end
		fast_cyc = sbcr_cnt_type'((21'(off_cyc) * 21'(`SBCR_FAST_NUM))
			>> `SBCR_FAST_SHIFT);
		slow_len = off_cyc - fast_cyc;
	end
	assign phase = {ctrl_q[`SBCR_CTRL_PH_B], ctrl_q[`SBCR_CTRL_PH_A]};
	assign level[0] = ctrl_q[`SBCR_CTRL_LVL_A +: 2];
	assign level[1] = ctrl_q[`SBCR_CTRL_LVL_B +: 2];
	for (genvar i = 0; i < 2; i++) begin : g_bridge
		assign run[i] = sleep_s & ~shut & ~s2g_q[i] &
			(level[i] != `SBCR_LVL_OFF);
		assign trip_ev[i] = run[i] && state_q[i] == ST_ON &&
			blank_q[i] == '0 && sense_s[i];
		// the latch holds through the short; it clears on wake from sleep
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				s2g_q[i] <= 1'b0;
			end else if (s2g_s[i]) begin
				s2g_q[i] <= 1'b1;
			end else if (sleep_rise) begin
				s2g_q[i] <= 1'b0;
			end
		end
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				state_q[i] <= ST_IDLE;
				tmr_q[i]   <= '0;
				blank_q[i] <= '0;
			end else if (!run[i]) begin
				state_q[i] <= ST_IDLE;
				tmr_q[i]   <= '0;
				blank_q[i] <= '0;
			end else begin
				unique case (state_q[i])
					ST_IDLE: begin
						state_q[i] <= ST_ON;
						blank_q[i] <= 6'(`SBCR_TBLANK_CYC);
					end
					ST_ON: begin
						if (blank_q[i] != '0) begin
							blank_q[i] <= blank_q[i] - 6'h01;
						end else if (sense_s[i]) begin
							state_q[i] <= ST_FAST;
							tmr_q[i]   <= off_cyc - sbcr_cnt_type'(1);
						end
					end
					ST_FAST: begin
						tmr_q[i] <= tmr_q[i] - sbcr_cnt_type'(1);
						if (tmr_q[i] <= slow_len) begin
							state_q[i] <= ST_SLOW;
						end
					end
					ST_SLOW: begin
						if (tmr_q[i] == '0) begin
							state_q[i] <= ST_ON;
							blank_q[i] <= 6'(`SBCR_TBLANK_CYC);
						end else begin
							tmr_q[i] <= tmr_q[i] - sbcr_cnt_type'(1);
						end
					end
				endcase
			end
		end
		// no dead time here; the analog drivers add crossover delay
		always_ff @(posedge clk_sys or negedge resetn) begin
			if (!resetn) begin
				gate_q[i] <= '0;
			end else if (!run[i]) begin
				gate_q[i] <= '0;
			end else begin
				unique case (state_q[i])
					ST_IDLE: gate_q[i] <= '0;
					ST_ON: begin
						gate_q[i] <= phase[i] ? `SBCR_GATE_FWD
							: `SBCR_GATE_REV;
					end
					ST_FAST: begin
						if (zero_s[i]) begin
							gate_q[i] <= '0;
						end else begin
							gate_q[i] <= phase[i] ? `SBCR_GATE_REV
								: `SBCR_GATE_FWD;
						end
					end
					ST_SLOW: begin
						gate_q[i] <= zero_s[i] ? 4'h0
							: `SBCR_GATE_SLOW;
					end
				endcase
			end
		end
		sequence s_trip_seen;
			run[i] && state_q[i] == ST_ON && blank_q[i] == '0 && sense_s[i];
		endsequence
		sequence s_fast_ends;
			run[i] && state_q[i] == ST_FAST && tmr_q[i] <= slow_len;
		endsequence
		a_trip_starts_off: assert property (@(posedge clk_sys)
			disable iff (!resetn)
			s_trip_seen ##1 run[i] |-> state_q[i] == ST_FAST
				&& tmr_q[i] == $past(off_cyc) - sbcr_cnt_type'(1)
				##1 !($past(phase[i]) ? gate_q[i].hs_a : gate_q[i].hs_b))
			else $error("trip did not start off-time");
		a_blank_ignores: assert property (@(posedge clk_sys)
			disable iff (!resetn)
			run[i] && state_q[i] == ST_ON && blank_q[i] != '0 ##1 run[i]
				|-> state_q[i] == ST_ON)
			else $error("comparator read during blanking");
		a_fast_to_slow: assert property (@(posedge clk_sys)
			disable iff (!resetn)
			s_fast_ends ##1 run[i] |-> state_q[i] == ST_SLOW)
			else $error("fast decay did not end on time");
		a_off_retry: assert property (@(posedge clk_sys)
			disable iff (!resetn)
			run[i] && state_q[i] == ST_SLOW && tmr_q[i] == '0 ##1 run[i]
				|-> state_q[i] == ST_ON && blank_q[i] == 6'(`SBCR_TBLANK_CYC))
			else $error("no retry after off-time");
		a_on_diagonal: assert property (@(posedge clk_sys)
			disable iff (!resetn)
			run[i] && state_q[i] == ST_ON |=>
				gate_q[i] == ($past(phase[i]) ? 4'h9 : 4'h6))
			else $error("wrong diagonal in on-phase");
		a_zero_no_rect: assert property (@(posedge clk_sys)
			disable iff (!resetn)
			(state_q[i] == ST_FAST || state_q[i] == ST_SLOW) && zero_s[i]
				|=> gate_q[i] == '0)
			else $error("rectification at zero current");
		a_s2g_holds: assert property (@(posedge clk_sys)
			disable iff (!resetn)
			s2g_q[i] && !sleep_rise |=> s2g_q[i] && gate_q[i] == '0)
			else $error("short latch released early");
		a_level_off: assert property (@(posedge clk_sys)
			disable iff (!resetn)
			level[i] == `SBCR_LVL_OFF |=> gate_q[i] == '0)
			else $error("disabled bridge still driven");
	end
	a_sleep_gates_off: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		!sleep_s |=> !charge_pump_en ##1 bridge_gate == '0)
		else $error("outputs active in sleep");
	a_fault_gates_off: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		gate_regulator_output_s |-> ##2 bridge_gate == '0)
		else $error("outputs active on regulator fault");
	a_shutdown_off: assert property (@(posedge clk_sys)
		disable iff (!resetn)
		ot_s || cpuv_s |-> ##2 bridge_gate == '0)
		else $error("outputs active during shutdown");

	// software-visible registers
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wr_fire = avs_write && !avs_waitrequest;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= `SBCR_CTRL_RST;
		end else if (wr_fire && avs_address == `SBCR_REG_CTRL) begin
			ctrl_q <= (ctrl_q & ~wmask[`SBCR_CTRL_W-1:0])
				| (avs_writedata[`SBCR_CTRL_W-1:0] & wmask[`SBCR_CTRL_W-1:0]);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			offt_q <= `SBCR_OFFT_RST;
		end else if (wr_fire && avs_address == `SBCR_REG_OFFT) begin
			offt_q <= (offt_q & ~wmask[`SBCR_OFFT_MODE:0])
				| (avs_writedata[`SBCR_OFFT_MODE:0] & wmask[`SBCR_OFFT_MODE:0]);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_en_q <= '0;
		end else if (wr_fire && avs_address == `SBCR_REG_IRQ_EN) begin
			irq_en_q <= (irq_en_q & ~wmask[`SBCR_IRQ_W-1:0])
				| (avs_writedata[`SBCR_IRQ_W-1:0] & wmask[`SBCR_IRQ_W-1:0]);
		end
	end

	assign irq_ev  = {ot_s, gate_regulator_output_s | cpuv_s, s2g_q, trip_ev};
	assign irq_clr = (wr_fire && avs_address == `SBCR_REG_IRQ_CLR)
		? avs_writedata[`SBCR_IRQ_W-1:0] & wmask[`SBCR_IRQ_W-1:0] : '0;

	// a new event in the clear cycle stays set
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_en_q);
		end
	end

	always_comb begin
		unique case (avs_address)
			`SBCR_REG_CTRL:     rd_mux = 32'(ctrl_q);
			`SBCR_REG_OFFT:     rd_mux = 32'(offt_q);
			`SBCR_REG_STATUS:   rd_mux = 32'({~sleep_s, shut, s2g_q,
				2'(state_q[1]), 2'(state_q[0])});
			`SBCR_REG_IRQ_STAT: rd_mux = 32'(irq_stat_q);
			`SBCR_REG_IRQ_EN:   rd_mux = 32'(irq_en_q);
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// one wait cycle per access; read data stand while waitrequest is low
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (avs_waitrequest && (avs_read || avs_write)) begin
			avs_waitrequest <= 1'b0;
			avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			charge_pump_en <= 1'b0;
			trip_level_sel <= 4'h0;
			bridge_gate    <= '0;
		end else begin
			charge_pump_en <= sleep_s;
			trip_level_sel <= {level[1], level[0]};
			bridge_gate    <= gate_q;
		end
	end
endmodule
`default_nettype wire

// ---- tb/sbcr_winding_model.sv ----
// behavioural model of the two windings with their sense comparators
`timescale 1ns/1ps
`default_nettype none
module sbcr_winding_model
	import sbcr_pkg::*;
(
	// clock
	input  wire logic                clk_sys,
	// drives from the regulator, and phase from the bench
	input  wire sbcr_gate_type [1:0] bridge_gate,
	input  wire logic [3:0]          trip_level_sel,
	input  wire logic [1:0]          phase,
	// fault injection from the bench
	input  wire logic [1:0]          short_load,
	input  wire logic [1:0]          leak,
	// comparator and zero-current outputs
	output logic [1:0]               sense,
	output logic [1:0]               zero_current
);
	logic [9:0] cur_q [2] = '{10'h000, 10'h000};
	logic [2:0] div_q = 3'h0;
	logic [3:0] on_p  [2];

	function automatic logic [9:0] thr(input logic [1:0] l);
		case (l)
			2'h0: thr = 10'h12c;
			2'h1: thr = 10'h0c8;
			2'h2: thr = 10'h064;
			default: thr = 10'h3ff;
		endcase
	endfunction

	// slow natural decay keeps zero current away unless leak is asked for
	always_ff @(posedge clk_sys) begin
		div_q <= div_q + 3'h1;
		for (int i = 0; i < 2; i++) begin
			if (4'(bridge_gate[i]) === on_p[i]) begin
				cur_q[i] <= (cur_q[i] > 10'h3e0) ? 10'h3e4 : cur_q[i] + 10'h004;
			end else if ((leak[i] || div_q == 3'h0) && cur_q[i] != 10'h000) begin
				cur_q[i] <= cur_q[i] - 10'h001;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			on_p[i] = phase[i] ? 4'h9 : 4'h6;
			sense[i] = short_load[i] | (cur_q[i] >= thr(trip_level_sel[2*i +: 2]));
			zero_current[i] = (cur_q[i] == 10'h000);
		end
	end
endmodule
`default_nettype wire

// ---- tb/sbcr_top_tb.sv ----
// self-checking bench for the stepper bridge current regulator
`timescale 1ns/1ps
`include "sbcr_params.svh"
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module sbcr_top_tb
	import sbcr_pkg::*;
;
	logic               clk_sys = 1'b0;
	logic               resetn = 1'b0;
	logic [4:0]         avs_address = 5'h00;
	logic               avs_read = 1'b0;
	logic               avs_write = 1'b0;
	logic [31:0]        avs_writedata = 32'h0;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	logic               irq;
	logic               sleep_n = 1'b1;
	logic [1:0]         sense, zero_current;
	logic [1:0]         stg = 2'h0, short_load = 2'h0, leak = 2'h0;
	logic [1:0]         phase = 2'h3;
	logic [2:0]         flt = 3'h0;
	sbcr_gate_type [1:0] bridge_gate;
	logic [3:0]         trip_level_sel;
	logic               charge_pump_en;
	int                 fail_count = 0;
	int                 check_count = 0;

	sbcr_top DUT (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .sleep_n(sleep_n),
		.bridge_a_sense_input(sense[0]), .bridge_b_sense_input(sense[1]),
		.zero_current(zero_current), .short_to_gnd(stg),
		.gate_regulator_fault(flt[0]), .overtemp(flt[1]),
		.charge_pump_reservoir_uv(flt[2]), .bridge_gate(bridge_gate),
		.trip_level_sel(trip_level_sel), .charge_pump_en(charge_pump_en));

	sbcr_winding_model winding (.clk_sys(clk_sys), .bridge_gate(bridge_gate),
		.trip_level_sel(trip_level_sel), .phase(phase), .short_load(short_load),
		.leak(leak), .sense(sense), .zero_current(zero_current));

	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		if (fail_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 20) begin
			fail_count++;
			report_and_stop();
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask

	task automatic wait_gate(input int b, input logic [3:0] v, input int lim);
		int n;
		n = 0;
		while (4'(bridge_gate[b]) !== v && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		`CHK(4'(bridge_gate[b]), v)
		if (n >= lim) report_and_stop();
	endtask

	task automatic count(input int b, input logic [3:0] v, output int n);
		n = 0;
		while (4'(bridge_gate[b]) === v && n < 5000) begin
			@(posedge clk_sys);
			n++;
		end
	endtask

	// one on-phase, then fast and slow decay lengths of the off-time
	task automatic meas(input int b, input logic [3:0] on_p, input int off,
		output int on_n);
		int nf, ns;
		wait_gate(b, on_p, 3000);
		count(b, on_p, on_n);
		count(b, ~on_p, nf);
		count(b, `SBCR_GATE_SLOW, ns);
		`CHK(nf, off * 5 / 16)
		`CHK(nf + ns, off)
		`CHK(4'(bridge_gate[b]), on_p)
	endtask

	function automatic int offc(input int r);
		offc = r * 40 / 825;
		if (offc < 1) offc = 1;
	endfunction

	initial begin
		logic [31:0] q;
		int r, n, k;
		logic [1:0] lb;
		void'($urandom(50));
		repeat (12) @(posedge clk_sys);
		`CHK({4'(bridge_gate[0]), charge_pump_en}, 5'h00)
		resetn <= 1'b1;
		rd(`SBCR_REG_CTRL, q);
		`CHK(q, 32'(`SBCR_CTRL_RST))
		rd(`SBCR_REG_OFFT, q);
		`CHK(q, 32'h0)
		rd(`SBCR_REG_IRQ_EN, q);
		`CHK(q, 32'h0)
		rd(`SBCR_REG_IRQ_CLR, q);
		`CHK(q, 32'h0)
		wr(5'h1c, 32'hffff_ffff);
		rd(5'h1c, q);
		`CHK(q, 32'h0)
		meas(0, `SBCR_GATE_FWD, `SBCR_TOFF_FIXED_CYC, n);
		wr(`SBCR_REG_CTRL, 32'h01);
		phase <= 2'h1;
		meas(1, `SBCR_GATE_REV, `SBCR_TOFF_FIXED_CYC, n);
		r = 1650 + int'($urandom % 20000);
		wr(`SBCR_REG_OFFT, {11'h0, 1'b1, 20'(r)});
		meas(0, `SBCR_GATE_FWD, offc(r), n);
		wr(`SBCR_REG_OFFT, 32'h0);
		for (k = 0; k < 4; k++) begin
			lb = 2'($urandom % 3);
			wr(`SBCR_REG_CTRL, {26'h0, lb, 1'b0, 2'(k), 1'b1});
			repeat (4) @(posedge clk_sys);
			`CHK(trip_level_sel, {lb, 2'(k)})
		end
		wait_gate(0, 4'h0, 50);
		wr(`SBCR_REG_CTRL, 32'h01);
		// a shorted load keeps the comparator high after every blanking
		short_load <= 2'h1;
		meas(0, `SBCR_GATE_FWD, `SBCR_TOFF_FIXED_CYC, n);
		meas(0, `SBCR_GATE_FWD, `SBCR_TOFF_FIXED_CYC, n);
		`CHK(n >= 40 && n <= 44, 1'b1)
		short_load <= 2'h0;
		leak <= 2'h1;
		wait_gate(0, `SBCR_GATE_FWD, 3000);
		wait_gate(0, `SBCR_GATE_REV, 3000);
		wait_gate(0, 4'h0, 1200);
		leak <= 2'h0;
		wr(`SBCR_REG_IRQ_EN, 32'h10);
		for (k = 0; k < 3; k++) begin
			wait_gate(0, `SBCR_GATE_FWD, 3000);
			flt <= 3'(1 << k);
			wait_gate(0, 4'h0, 20);
			repeat (4) @(posedge clk_sys);
			`CHK({4'(bridge_gate[1]), irq}, {4'h0, k != 1})
			flt <= 3'h0;
			wr(`SBCR_REG_IRQ_CLR, 32'h10);
			wait_gate(0, `SBCR_GATE_FWD, 3000);
		end
		wr(`SBCR_REG_IRQ_EN, 32'h04);
		stg <= 2'h1;
		wait_gate(0, 4'h0, 20);
		stg <= 2'h0;
		repeat (100) @(posedge clk_sys);
		rd(`SBCR_REG_STATUS, q);
		`CHK({4'(bridge_gate[0]), q[4], irq}, 6'h03)
		sleep_n <= 1'b0;
		wait_gate(1, 4'h0, 20);
		rd(`SBCR_REG_STATUS, q);
		`CHK({charge_pump_en, q[7]}, 2'h1)
		rd(`SBCR_REG_IRQ_STAT, q);
		`CHK(q[2:0], 3'h7)
		wr(`SBCR_REG_IRQ_CLR, 32'h3);
		rd(`SBCR_REG_IRQ_STAT, q);
		`CHK(q[2:0], 3'h4)
		wr(`SBCR_REG_IRQ_EN, 32'h01);
		repeat (3) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		sleep_n <= 1'b1;
		repeat (40000) @(posedge clk_sys);
		wait_gate(0, `SBCR_GATE_FWD, 3000);
		report_and_stop();
	end

	initial begin
		repeat (99000) @(posedge clk_sys);
		fail_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
